// *** core/pg_pkg.sv ***
/*
 Shared constants and state types of the emulator pod glue logic.
 Assumes a single processor clock domain.
*/
`default_nettype none
package pg_pkg;
    // Encoded priority lines, active low
    localparam logic [2:0] PG_IPL_NONE = 3'h7;
    localparam logic [2:0] PG_IPL_SEVEN = 3'h0;
    // Low address bits of a level 7 acknowledge
    localparam logic [2:0] PG_LEVEL_SEVEN = 3'h7;
    // Peripheral enable clock: period and high phase in clocks
    localparam int unsigned PG_E_PERIOD = 10;
    localparam int unsigned PG_E_HIGH = 4;
    // Halt delay in clocks when the option is on
    localparam int unsigned PG_HALT_DLY_CYC = 2;
    // Bit positions inside the synchroniser vector
    localparam int unsigned PG_SY_RST = 3;
    localparam int unsigned PG_SY_VPA = 4;
    localparam int unsigned PG_SY_BERR = 5;
    localparam int unsigned PG_SY_BRK = 6;

    typedef struct packed {
        logic [6:0] sync1;
        logic [6:0] sync2;
        logic asPrev;
        logic [2:0] fcLatN;
        logic [3:0] eCnt;
        logic eOut;
        logic [PG_HALT_DLY_CYC-1:0] haltShift;
        logic xAck;
        logic [15:0] bdata;
        logic bdOe;
    } pg_state_t;

    // Active-low lines synchronise high, break request low
    localparam pg_state_t PG_STATE_RST = '{7'h3f, 7'h3f, 1'b1, 3'h7,
        4'h0, 1'b0, {PG_HALT_DLY_CYC{1'b1}}, 1'b0, 16'h0000, 1'b0};

    typedef struct packed {
        logic prev;
        logic pend;
        logic irqN;
        logic ack;
    } pg_brk_t;

    localparam pg_brk_t PG_BRK_RST = '{1'b0, 1'b0, 1'b1, 1'b0};
endpackage
`default_nettype wire

// *** core/pg_brk_if.sv ***
/*
 Carrier between the glue top and its level 7 break unit.
 Assumes both ends run on the same processor clock.
*/
`default_nettype none
interface pg_brk_if;
    logic ce;
    logic brkLvl;
    logic breakUse;
    logic l7PendN;
    logic l7AckCyc;
    logic cycEnd;
    logic irqN;
    logic ackN;
    modport top (output ce, brkLvl, breakUse, l7PendN, l7AckCyc, cycEnd,
        input irqN, ackN);
    modport brk (input ce, brkLvl, breakUse, l7PendN, l7AckCyc, cycEnd,
        output irqN, ackN);
endinterface
`default_nettype wire

// *** core/pg_break_l7.sv ***
/*
 Level 7 break unit: catches the break request edge, holds it off
 while a user level 7 request is pending, and tracks the acknowledge.
 Assumes brkLvl is already synchronised to clk.
*/
`default_nettype none
module pg_break_l7 (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Link to the glue top
    pg_brk_if.brk bi
);
    import pg_pkg::*;

    pg_brk_t s_reg;
    pg_brk_t s_next;
    logic rise;
    logic fire;

    always_comb begin
        s_next = s_reg;
        rise = bi.brkLvl & ~s_reg.prev;
        // Postponed while a user level 7 is pending
        fire = s_reg.pend & bi.l7PendN & s_reg.irqN;
        s_next.prev = bi.brkLvl;
        // Option low clocks a high: nothing is taken
        s_next.pend = (rise & bi.breakUse) | (s_reg.pend & ~fire);
        if (fire) begin
            s_next.irqN = 1'b0;
        end
        if (~s_reg.irqN & bi.l7AckCyc) begin
            s_next.ack = 1'b1;
        end
        if (s_reg.ack & bi.cycEnd) begin
            s_next.ack = 1'b0;
            s_next.irqN = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= PG_BRK_RST;
        end else if (bi.ce) begin
            s_reg <= s_next;
        end
    end

    assign bi.irqN = s_reg.irqN;
    assign bi.ackN = ~s_reg.ack;

    brk_fire_a: assert property (@(posedge clk) disable iff (!rst_n)
        (bi.ce && bi.brkLvl && !s_reg.prev && bi.breakUse && bi.l7PendN && bi.irqN)
        ##1 (bi.ce && bi.l7PendN) |=> !bi.irqN)
        else $error("break edge did not raise level 7");
    brk_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!bi.l7PendN && bi.irqN) |=> bi.irqN)
        else $error("break not held off by pending level 7");
endmodule
`default_nettype wire

// *** core/pg_glue_top.sv ***
/*
 Emulator pod glue logic: interrupt acknowledge decode, user interrupt
 gating, break injection, target buffer steering, mapper select, DMA
 options, extra DTACK, peripheral enable clock, halt delay and the
 performance latch readback.
 Assumes processor bus signals are on clk; target pins are asynchronous.
*/
//
// Operation
// - Interrupt acknowledge decode from address, function code
// - User acknowledge passes VPA and BERR through
// - Interrupt enable off masks all target levels
// - Buffered gate off: out-of-circuit, control, break
// - Pending user level 7 postpones break
// - Low address bits 111 flag level 7
// - Index bit five routes writes to mapper
// - Transceivers enabled only while enable low
// - Reset seen from target or reset instruction
// - Total reset start needs halt and reset
// - Target buffer enable dropped on reset, halt, idle
// - Odd flag follows A0 on narrow bus
// - Direction low writes to target, high reads
// - Extra open-collector ack for target DMA
// - Peripheral enable period is ten clocks
// - First latch control reads two latches
// - Second latch control reads byte plus three bits
// - Mapper select from address or latched status
// - DMA block hides DMA, memory silent
// - DMA monitor shows DMA, memory silent
// - Break use option decides interrupt on edge
// - Halt delay option delays halt to processor
// - Break flop low drives level 7 priority
`default_nettype none
module pg_glue_top #(
    parameter bit NarrowBus = 1'b0,
    parameter int unsigned EPeriod = pg_pkg::PG_E_PERIOD,
    parameter int unsigned EHigh = pg_pkg::PG_E_HIGH
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // Emulation processor bus
    input wire logic [23:0] addr,
    input wire logic [2:0] funcCode,
    input wire logic asN,
    input wire logic rw,
    input wire logic procResetOutN,
    input wire logic haltRequestN,
    input wire logic busGrantedDma,
    input wire logic emulMemDone,
    input wire logic userAccess,
    output logic procVpaN,
    output logic procBerrN,
    output logic procDtackN,
    output logic [2:0] priorityLevelInputsN,
    output logic haltToProcN,
    // Target pins
    input wire logic [2:0] tgtIplN,
    input wire logic tgtResetN,
    input wire logic tgtVpaN,
    input wire logic tgtBerrN,
    output logic extraTransferAckOut,
    output logic extraTransferAckOe,
    output logic peripheralEnable,
    output logic targetBuffersEnableN,
    output logic probeDatabusEnableN,
    output logic probeDatabusDirection,
    output logic strobeDisable,
    output logic oddAddr,
    // Break request from the emulation system
    input wire logic breakRequestEdge,
    // Configuration
    input wire logic inCircuit,
    input wire logic userIrqEnableCfgN,
    input wire logic userIrqMaskCtl,
    input wire logic breakUseOption,
    input wire logic dmaBlockOption,
    input wire logic dmaMonitorOption,
    input wire logic haltDelayOption,
    input wire logic funccodeMapSelectN,
    input wire logic mapperWriteSelectN,
    // Host access
    input wire logic hostWriteN,
    input wire logic hostPodReadN,
    input wire logic perfLatchReadAN,
    input wire logic perfLatchReadBN,
    input wire logic [7:0] perfLatch0,
    input wire logic [7:0] perfLatch1,
    input wire logic [7:0] perfLatch2,
    input wire logic [2:0] perfLatch3,
    output logic [15:0] bufferedDataBits,
    output logic bufferedDataBitsOe,
    output logic mapperWriteN,
    output logic podRegWriteN,
    // Decodes and status
    output logic intAckDecodeN,
    output logic lowAddrIsSevenN,
    output logic userLevelSevenPendingN,
    output logic userIrqGateBufferedN,
    output logic levelSevenIrqOutN,
    output logic breakAckN,
    output logic systemResetSeenN,
    output logic totalResetStartN,
    output logic [2:0] mapperAddrSelect,
    output logic [2:0] latchedFuncCodeStatusN,
    output logic analysisVisible,
    output logic emulMemRespond
);
    import pg_pkg::*;

    localparam int unsigned ELow = EPeriod - EHigh;
    localparam logic [3:0] ELast = 4'(EPeriod - 1);
    localparam logic [3:0] EHighStart = 4'(ELow);

    pg_state_t s_reg;
    pg_state_t s_next;
    pg_brk_if bi ();

    logic intAck;
    logic memCyc;
    logic [2:0] iplS;
    logic gateOn;
    logic rdA;
    logic rdB;
    logic [3:0] eNext;

    pg_break_l7 u_brk (
        .clk(clk),
        .rst_n(rst_n),
        .bi(bi)
    );

    assign iplS = s_reg.sync2[2:0];
    assign memCyc = ~asN;

    // Bus cycle decodes
    assign intAck = (&addr[23:4]) & (&funcCode);
    assign intAckDecodeN = ~intAck;
    assign lowAddrIsSevenN = ~(addr[3:1] == PG_LEVEL_SEVEN);
    assign userLevelSevenPendingN = ~(iplS == PG_IPL_SEVEN);

    // Break unit hookup
    assign bi.ce = ce;
    assign bi.brkLvl = s_reg.sync2[PG_SY_BRK];
    assign bi.breakUse = breakUseOption;
    assign bi.l7PendN = userLevelSevenPendingN;
    assign bi.l7AckCyc = intAck & ~lowAddrIsSevenN & memCyc;
    assign bi.cycEnd = asN & ~s_reg.asPrev;
    assign levelSevenIrqOutN = bi.irqN;
    assign breakAckN = bi.ackN;
    // Keeps the break acknowledge off the target strobes
    assign strobeDisable = ~bi.ackN;

    // User interrupt gating
    assign gateOn = ~userIrqEnableCfgN & inCircuit & ~userIrqMaskCtl
        & bi.irqN & bi.ackN;
    assign userIrqGateBufferedN = ~gateOn;

    always_comb begin
        if (!bi.irqN) begin
            priorityLevelInputsN = PG_IPL_SEVEN;
        end else if (gateOn) begin
            priorityLevelInputsN = iplS;
        end else begin
            priorityLevelInputsN = PG_IPL_NONE;
        end
    end

    // VPA and BERR reach the processor on user acknowledges and user accesses
    always_comb begin
        procVpaN = 1'b1;
        procBerrN = 1'b1;
        if (intAck ? bi.ackN : userAccess) begin
            procVpaN = s_reg.sync2[PG_SY_VPA];
            procBerrN = s_reg.sync2[PG_SY_BERR];
        end
    end

    // Break acknowledge answers itself with the jammed vector
    assign procDtackN = ~(intAck & ~bi.ackN & memCyc);

    // Reset and halt
    assign systemResetSeenN = s_reg.sync2[PG_SY_RST] & procResetOutN;
    assign totalResetStartN = haltRequestN | systemResetSeenN;
    assign haltToProcN = haltDelayOption ? s_reg.haltShift[PG_HALT_DLY_CYC-1]
        : haltRequestN;

    // Target buffers and data transceivers
    assign targetBuffersEnableN = ~(inCircuit & systemResetSeenN
        & haltRequestN & (busGrantedDma | memCyc));
    assign probeDatabusEnableN = ~(inCircuit & memCyc & bi.ackN
        & (userAccess | busGrantedDma | intAck));
    // Under DMA the target drives, so a target write flows inward
    assign probeDatabusDirection = busGrantedDma ? ~rw : rw;
    assign oddAddr = NarrowBus ? addr[0] : 1'b1;

    // Mapper addressing and host writes
    assign mapperAddrSelect = funccodeMapSelectN ? addr[11:9]
        : s_reg.fcLatN;
    assign latchedFuncCodeStatusN = s_reg.fcLatN;
    assign mapperWriteN = hostWriteN | mapperWriteSelectN;
    assign podRegWriteN = hostWriteN | ~mapperWriteSelectN;

    // DMA tracing options
    assign analysisVisible = ~busGrantedDma
        | (dmaMonitorOption & ~dmaBlockOption);
    assign emulMemRespond = ~busGrantedDma
        | ~(dmaBlockOption | dmaMonitorOption);

    // Extra DTACK is open collector: only ever pulls low
    assign extraTransferAckOut = 1'b0;
    assign extraTransferAckOe = s_reg.xAck;

    assign peripheralEnable = s_reg.eOut;
    assign bufferedDataBits = s_reg.bdata;
    assign bufferedDataBitsOe = s_reg.bdOe;

    // Latch readback decodes
    assign rdA = ~hostPodReadN & ~perfLatchReadAN & ~addr[1];
    assign rdB = ~hostPodReadN & ~perfLatchReadBN & addr[1];

    always_comb begin
        s_next = s_reg;
        s_next.sync1 = {breakRequestEdge, tgtBerrN, tgtVpaN, tgtResetN, tgtIplN};
        s_next.sync2 = s_reg.sync1;
        s_next.asPrev = asN;
        if (s_reg.asPrev & ~asN) begin
            s_next.fcLatN = ~funcCode;
        end
        eNext = (s_reg.eCnt == ELast) ? 4'h0 : 4'(s_reg.eCnt + 4'h1);
        s_next.eCnt = eNext;
        s_next.eOut = (eNext >= EHighStart);
        s_next.haltShift = {s_reg.haltShift[PG_HALT_DLY_CYC-2:0], haltRequestN};
        // Held until the DMA device ends its strobe
        s_next.xAck = memCyc & busGrantedDma & emulMemRespond
            & (s_reg.xAck | emulMemDone);
        if (rdA) begin
            s_next.bdata = {perfLatch1, perfLatch0};
        end else if (rdB) begin
            s_next.bdata = {5'h00, perfLatch3, perfLatch2};
        end
        s_next.bdOe = rdA | rdB;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= PG_STATE_RST;
        end else if (ce) begin
            s_reg <= s_next;
        end
    end

    vpa_pass_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!intAckDecodeN && breakAckN) |-> (procVpaN == s_reg.sync2[PG_SY_VPA]))
        else $error("VPA not passed on user acknowledge");
    irq_mask_a: assert property (@(posedge clk) disable iff (!rst_n)
        (userIrqEnableCfgN && levelSevenIrqOutN) |-> priorityLevelInputsN == 3'h7)
        else $error("target interrupt leaked while disabled");
    gate_off_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!inCircuit || userIrqMaskCtl || !levelSevenIrqOutN) |-> userIrqGateBufferedN)
        else $error("buffered interrupt gate open");
    l7_drive_a: assert property (@(posedge clk) disable iff (!rst_n)
        !levelSevenIrqOutN |-> priorityLevelInputsN == 3'h0)
        else $error("level 7 not presented");
    reset_start_a: assert property (@(posedge clk) disable iff (!rst_n)
        !totalResetStartN |-> (!haltRequestN && !systemResetSeenN))
        else $error("total reset start without halt and reset");
    tgt_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && !tgtResetN)[*3] |-> !systemResetSeenN)
        else $error("target reset not seen");
    e_period_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && $rose(peripheralEnable)) ##1 ce[*8] ##1 ce |=> $rose(peripheralEnable))
        else $error("peripheral enable period wrong");
    halt_dly_a: assert property (@(posedge clk) disable iff (!rst_n)
        ce ##1 ce ##1 haltDelayOption |-> haltToProcN == $past(haltRequestN, 2))
        else $error("halt not delayed by two clocks");
    xack_a: assert property (@(posedge clk) disable iff (!rst_n)
        ($past(ce) && extraTransferAckOe) |-> ($past(busGrantedDma) && !$past(asN)))
        else $error("extra ack outside a DMA cycle");
    perf_a_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && !hostPodReadN && !perfLatchReadAN && !addr[1])
        |=> bufferedDataBits == {$past(perfLatch1), $past(perfLatch0)})
        else $error("first latch pair not read back");
    dma_block_a: assert property (@(posedge clk) disable iff (!rst_n)
        (busGrantedDma && dmaBlockOption) |-> (!analysisVisible && !emulMemRespond))
        else $error("blocked DMA visible or answered");
endmodule
`default_nettype wire

// *** dv/pg_target_model.sv ***
/*
 Target system model: drives the target interrupt, reset, VPA and BERR
 pins, and pulls up the open-collector transfer acknowledge line.
 Assumes the bench sets the wanted pin levels just after a clock edge.
*/
`default_nettype none
module pg_target_model (
    // Wanted levels from the bench
    input wire logic [2:0] wantIplN,
    input wire logic wantResetN,
    input wire logic wantVpaN,
    input wire logic wantBerrN,
    // Target pins
    output logic [2:0] tgtIplN,
    output logic tgtResetN,
    output logic tgtVpaN,
    output logic tgtBerrN,
    // Open-collector acknowledge
    input wire logic ackOut,
    input wire logic ackOe,
    output logic ackWire
);
    timeunit 1ns;
    timeprecision 100ps;
    // Pins move a little after the request, unrelated to the clock edge
    assign #2 tgtIplN = wantIplN;
    assign #2 tgtResetN = wantResetN;
    assign #2 tgtVpaN = wantVpaN;
    assign #2 tgtBerrN = wantBerrN;
    // Pull-up holds the line high unless the pod pulls it
    assign ackWire = ackOe ? ackOut : 1'b1;
endmodule
`default_nettype wire

// *** dv/pg_glue_top_tb_top.sv ***
/*
 Self-checking bench of the pod glue logic with a target model.
 Assumes the glue top and the target model are compiled before it.
*/
`default_nettype none
module pg_glue_top_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import pg_pkg::*;
    logic clk, rst_n = 1'b0, ce = 1'b1, asN = 1'b1, rw = 1'b1, procResetOutN = 1'b1, haltRequestN = 1'b1;
    logic [23:0] addr = 24'h000000;
    logic [2:0] funcCode = 3'h0, wantIplN = 3'h7, tgtIplN, priorityLevelInputsN, mapperAddrSelect;
    logic [2:0] latchedFuncCodeStatusN, perfLatch3 = 3'h5;
    logic busGrantedDma = 1'b0, emulMemDone = 1'b0, userAccess = 1'b0, wantResetN = 1'b1, wantVpaN = 1'b1;
    logic wantBerrN = 1'b1, breakRequestEdge = 1'b0, inCircuit = 1'b1, userIrqEnableCfgN = 1'b0;
    logic userIrqMaskCtl = 1'b0, breakUseOption = 1'b0, dmaBlockOption = 1'b0, dmaMonitorOption = 1'b0;
    logic haltDelayOption = 1'b0, funccodeMapSelectN = 1'b1, mapperWriteSelectN = 1'b1, hostWriteN = 1'b1;
    logic hostPodReadN = 1'b1, perfLatchReadAN = 1'b1, perfLatchReadBN = 1'b1;
    logic [7:0] perfLatch0 = 8'h5a, perfLatch1 = 8'hc3, perfLatch2 = 8'h96;
    logic [15:0] bufferedDataBits;
    logic tgtResetN, tgtVpaN, tgtBerrN, procVpaN, procBerrN, procDtackN, haltToProcN, extraTransferAckOut;
    logic extraTransferAckOe, peripheralEnable, targetBuffersEnableN, probeDatabusEnableN, ackWire;
    logic probeDatabusDirection, strobeDisable, oddAddr, bufferedDataBitsOe, mapperWriteN, podRegWriteN;
    logic intAckDecodeN, lowAddrIsSevenN, userLevelSevenPendingN, userIrqGateBufferedN, levelSevenIrqOutN;
    logic breakAckN, systemResetSeenN, totalResetStartN, analysisVisible, emulMemRespond;
    int num_errors = 0, cmp_count = 0, cycles = 0;

    pg_glue_top i_pg_glue_top (.clk, .rst_n, .ce, .addr, .funcCode, .asN, .rw, .procResetOutN, .haltRequestN,
        .busGrantedDma, .emulMemDone, .userAccess, .procVpaN, .procBerrN, .procDtackN, .priorityLevelInputsN,
        .haltToProcN, .tgtIplN, .tgtResetN, .tgtVpaN, .tgtBerrN, .extraTransferAckOut, .extraTransferAckOe,
        .peripheralEnable, .targetBuffersEnableN, .probeDatabusEnableN, .probeDatabusDirection, .strobeDisable,
        .oddAddr, .breakRequestEdge, .inCircuit, .userIrqEnableCfgN, .userIrqMaskCtl, .breakUseOption,
        .dmaBlockOption, .dmaMonitorOption, .haltDelayOption, .funccodeMapSelectN, .mapperWriteSelectN,
        .hostWriteN, .hostPodReadN, .perfLatchReadAN, .perfLatchReadBN, .perfLatch0, .perfLatch1, .perfLatch2,
        .perfLatch3, .bufferedDataBits, .bufferedDataBitsOe, .mapperWriteN, .podRegWriteN, .intAckDecodeN,
        .lowAddrIsSevenN, .userLevelSevenPendingN, .userIrqGateBufferedN, .levelSevenIrqOutN, .breakAckN,
        .systemResetSeenN, .totalResetStartN, .mapperAddrSelect, .latchedFuncCodeStatusN, .analysisVisible,
        .emulMemRespond);

    pg_target_model i_pg_target_model (.wantIplN, .wantResetN, .wantVpaN, .wantBerrN, .tgtIplN, .tgtResetN,
        .tgtVpaN, .tgtBerrN, .ackOut(extraTransferAckOut), .ackOe(extraTransferAckOe), .ackWire);

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk(input string what, input logic [15:0] expv, input logic [15:0] got);
        cmp_count++;
        if (got !== expv) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, expv, got);
        end
    endtask

    task automatic wait_for(ref logic sig, input logic val, input int lim);
        int n;
        n = 0;
        while (sig !== val && n < lim) begin
            step(1);
            n++;
        end
    endtask

    task automatic fin(input string name);
        $display("test %s finished, mismatches so far %0d", name, num_errors);
    endtask

    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            $display("[ERR] run length expected below %0d seen %0d", 3000, cycles);
            end_of_test();
        end
    end

    task automatic t_decode();
        addr = 24'hfffffe; funcCode = 3'h7; asN = 1'b0; userAccess = 1'b1; hostWriteN = 1'b0; step(1);
        chk("ack decode", 1'b0, intAckDecodeN);
        chk("level seven", 1'b0, lowAddrIsSevenN);
        chk("odd flag", 1'b1, oddAddr);
        chk("databus enable", 1'b0, probeDatabusEnableN);
        chk("direction read", 1'b1, probeDatabusDirection);
        chk("pod write", 1'b0, podRegWriteN);
        funcCode = 3'h6; addr = 24'h000a00; rw = 1'b0; userAccess = 1'b0; mapperWriteSelectN = 1'b0; step(1);
        chk("ack decode fc", 1'b1, intAckDecodeN);
        chk("level seven off", 1'b1, lowAddrIsSevenN);
        chk("addr select", 3'h5, mapperAddrSelect);
        chk("databus idle", 1'b1, probeDatabusEnableN);
        chk("direction write", 1'b0, probeDatabusDirection);
        chk("mapper write", 1'b0, mapperWriteN);
        chk("pod write off", 1'b1, podRegWriteN);
        asN = 1'b1; funcCode = 3'h1; funccodeMapSelectN = 1'b0; hostWriteN = 1'b1; rw = 1'b1; step(1);
        asN = 1'b0; step(2);
        chk("status select", 3'h6, mapperAddrSelect);
        chk("status latch", 3'h6, latchedFuncCodeStatusN);
        asN = 1'b1; funccodeMapSelectN = 1'b1; mapperWriteSelectN = 1'b1; step(1);
        fin("decode");
    endtask

    task automatic t_irq();
        wantIplN = 3'h5; wantVpaN = 1'b0; wantBerrN = 1'b0; step(3);
        chk("priority passed", 3'h5, priorityLevelInputsN);
        chk("gate on", 1'b0, userIrqGateBufferedN);
        userIrqEnableCfgN = 1'b1; step(1);
        chk("priority cfg off", PG_IPL_NONE, priorityLevelInputsN);
        userIrqEnableCfgN = 1'b0; userIrqMaskCtl = 1'b1; step(1);
        chk("priority masked", PG_IPL_NONE, priorityLevelInputsN);
        chk("gate masked", 1'b1, userIrqGateBufferedN);
        userIrqMaskCtl = 1'b0; inCircuit = 1'b0; step(1);
        chk("priority out of circuit", PG_IPL_NONE, priorityLevelInputsN);
        inCircuit = 1'b1; wantIplN = 3'h0; addr = 24'hfffff0; funcCode = 3'h7; asN = 1'b0; step(3);
        chk("seven pending", 1'b0, userLevelSevenPendingN);
        chk("vpa passed", 1'b0, procVpaN);
        chk("berr passed", 1'b0, procBerrN);
        addr = 24'h001000; step(1);
        chk("vpa blocked", 1'b1, procVpaN);
        asN = 1'b1; wantVpaN = 1'b1; wantBerrN = 1'b1; step(3);
        fin("irq");
    endtask

    task automatic t_break();
        breakRequestEdge = 1'b1; step(8);
        chk("option off", 1'b1, levelSevenIrqOutN);
        breakRequestEdge = 1'b0; breakUseOption = 1'b1; step(3);
        breakRequestEdge = 1'b1; step(8);
        chk("held off", 1'b1, levelSevenIrqOutN);
        wantIplN = 3'h7;
        wait_for(levelSevenIrqOutN, 1'b0, 12);
        chk("break irq", 1'b0, levelSevenIrqOutN);
        chk("priority seven", PG_IPL_SEVEN, priorityLevelInputsN);
        addr = 24'hffffff; funcCode = 3'h7; asN = 1'b0;
        wait_for(breakAckN, 1'b0, 4);
        chk("break ack", 1'b0, breakAckN);
        chk("dtack", 1'b0, procDtackN);
        asN = 1'b1; step(2);
        chk("irq released", 1'b1, levelSevenIrqOutN);
        breakRequestEdge = 1'b0; step(3);
        breakRequestEdge = 1'b1; step(4);
        chk("break prompt", 1'b0, levelSevenIrqOutN);
        asN = 1'b0; step(1);
        chk("strobe disable", 1'b1, strobeDisable);
        asN = 1'b1; step(2);
        chk("irq released again", 1'b1, levelSevenIrqOutN);
        breakRequestEdge = 1'b0; breakUseOption = 1'b0; step(3);
        fin("break");
    endtask

    task automatic t_reset();
        addr = 24'h000100; funcCode = 3'h5; asN = 1'b0; step(1);
        chk("buffers on", 1'b0, targetBuffersEnableN);
        wantResetN = 1'b0; step(3);
        chk("reset seen", 1'b0, systemResetSeenN);
        chk("start no halt", 1'b1, totalResetStartN);
        chk("buffers reset", 1'b1, targetBuffersEnableN);
        haltRequestN = 1'b0; step(1);
        chk("start", 1'b0, totalResetStartN);
        wantResetN = 1'b1; step(3);
        chk("buffers halt", 1'b1, targetBuffersEnableN);
        haltRequestN = 1'b1; procResetOutN = 1'b0; step(1);
        chk("reset instr", 1'b0, systemResetSeenN);
        procResetOutN = 1'b1; asN = 1'b1; step(1);
        chk("buffers idle", 1'b1, targetBuffersEnableN);
        fin("reset");
    endtask

    task automatic t_halt();
        haltRequestN = 1'b0; step(1);
        chk("halt direct", 1'b0, haltToProcN);
        haltRequestN = 1'b1; haltDelayOption = 1'b1; step(3);
        haltRequestN = 1'b0; step(1);
        chk("halt delayed", 1'b1, haltToProcN);
        step(PG_HALT_DLY_CYC - 1);
        chk("halt arrives", 1'b0, haltToProcN);
        haltRequestN = 1'b1; haltDelayOption = 1'b0; step(3);
        fin("halt");
    endtask

    task automatic t_eclk();
        int hi;
        hi = 0;
        wait_for(peripheralEnable, 1'b0, 12);
        wait_for(peripheralEnable, 1'b1, 12);
        repeat (PG_E_PERIOD) begin
            hi += int'(peripheralEnable);
            step(1);
        end
        chk("e high count", 16'(PG_E_HIGH), 16'(hi));
        chk("e next rise", 1'b1, peripheralEnable);
        ce = 1'b0; step(5);
        chk("e frozen", 1'b1, peripheralEnable);
        ce = 1'b1; step(1);
        fin("eclk");
    endtask

    task automatic t_perf();
        addr = 24'h000000; perfLatchReadAN = 1'b0; hostPodReadN = 1'b0; step(1);
        hostPodReadN = 1'b1;
        chk("latch pair", 16'hc35a, bufferedDataBits);
        chk("data out", 1'b1, bufferedDataBitsOe);
        addr = 24'h000002; perfLatchReadAN = 1'b1; perfLatchReadBN = 1'b0; step(1);
        chk("one read only", 1'b0, bufferedDataBitsOe);
        hostPodReadN = 1'b0; step(1);
        hostPodReadN = 1'b1;
        chk("byte plus three", 16'h0596, bufferedDataBits);
        perfLatchReadBN = 1'b1; step(1);
        fin("perf");
    endtask

    task automatic t_dma();
        busGrantedDma = 1'b1; dmaBlockOption = 1'b1; step(1);
        chk("block hidden", 1'b0, analysisVisible);
        chk("block silent", 1'b0, emulMemRespond);
        chk("dma direction", 1'b0, probeDatabusDirection);
        dmaBlockOption = 1'b0; dmaMonitorOption = 1'b1; step(1);
        chk("monitor seen", 1'b1, analysisVisible);
        chk("monitor silent", 1'b0, emulMemRespond);
        dmaMonitorOption = 1'b0; asN = 1'b0; emulMemDone = 1'b1; step(1);
        chk("extra ack", 1'b0, ackWire);
        asN = 1'b1; emulMemDone = 1'b0; step(1);
        chk("extra ack off", 1'b1, ackWire);
        busGrantedDma = 1'b0; step(1);
        fin("dma");
    endtask

    initial begin
        step(10);
        rst_n = 1'b1;
        step(2);
        chk("irq after reset", 1'b1, levelSevenIrqOutN);
        t_decode();
        t_irq();
        t_break();
        t_reset();
        t_halt();
        t_eclk();
        t_perf();
        t_dma();
        end_of_test();
    end
endmodule
`default_nettype wire
